// file: nv_access_pkg.sv
// Purpose: Shared constants and carriers for the storage access block
// Assumes: 8-bit register index, 16-bit register data
// Notes: Offsets are register indexes on the serial register port
package nv_access_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [7:0] OFF_WRITE_WORD = 8'h34;
  localparam logic [7:0] OFF_ACCESS_CTRL = 8'h35;
  localparam logic [7:0] OFF_READ_WORD = 8'h36;
  localparam logic [7:0] OFF_MOTOR_HOLD = 8'h60;
  localparam logic [7:0] OFF_ADDR_SEL = 8'h33;
  localparam logic [7:0] GAP1_LO = 8'h37;
  localparam logic [7:0] GAP1_HI = 8'h5f;
  localparam logic [7:0] GAP2_LO = 8'h61;
  localparam logic [7:0] GAP2_HI = 8'h8f;
  localparam int BIT_SHADOW = 12;
  localparam int BIT_RELOAD = 8;
  localparam int BIT_DIR = 2;
  localparam int BIT_MOTOR_HOLD = 15;
  localparam logic [15:0] CTRL_MASK = 16'h1107;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [1:0] MODE_OFF = 2'b00;
  localparam logic [1:0] MODE_SINGLE = 2'b01;
  localparam logic [1:0] MODE_BULK = 2'b10;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_req_s;
  typedef struct packed {
    logic req;
    logic write;
    logic [7:0] loc;
    logic [15:0] wdata;
  } nv_req_s;
endpackage

// file: nv_single_seq.sv
// Purpose: Sequences one single-location storage read or write
// Assumes: Storage answers with a one-cycle done pulse
// Notes: Go is a one-cycle pulse from the register block
`timescale 1ns/1ps
module nv_single_seq (
  input wire logic clk,
  input wire logic reset,
  input wire logic go,
  input wire logic write,
  input wire logic [7:0] loc,
  input wire logic [15:0] wdata,
  input wire logic nv_done,
  input wire logic [15:0] nv_rdata,
  output nv_access_pkg::nv_req_s nv_req,
  output logic busy,
  output logic rd_valid,
  output logic [15:0] rd_data
);
  typedef enum logic [1:0] {IDLE = 2'b00, WAIT = 2'b01} st_e;
  st_e state_r;
  logic write_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= IDLE;
      nv_req <= '0;
      write_r <= 1'b0;
    end else begin
      case (state_r)
        IDLE: begin
          if (go) begin
            state_r <= WAIT;
            nv_req <= '{req: 1'b1, write: write, loc: loc, wdata: wdata};
            write_r <= write;
          end
        end
        WAIT: begin
          if (nv_done) begin
            state_r <= IDLE;
            nv_req.req <= 1'b0;
          end
        end
        default: state_r <= IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_valid <= 1'b0;
      rd_data <= nv_access_pkg::RESET_WORD;
    end else begin
      rd_valid <= (state_r == WAIT) && nv_done && !write_r;
      if ((state_r == WAIT) && nv_done && !write_r) begin
        rd_data <= nv_rdata;
      end
    end
  end

  assign busy = (state_r != IDLE);
endmodule // nv_single_seq

// file: nv_access_regs.sv
// Purpose: Storage access control registers behind the register port
// Assumes: One register access per cycle, read data valid next cycle
// Notes: Shadow contents and storage live outside this block
//
// Contract
// - The write word is the value stored at the selected location.
// - With shadow override set, operation uses the shadow values.
// - With shadow override set, register reads return shadow contents.
// - With shadow override clear, shadows are not used for operation.
// - Setting the reload bit copies storage into the shadows.
// - The direction bit selects read at 0 and write at 1.
// - Mode 00 is off, 01 single, 10 bulk; the host never writes 11.
// - The read word shows the value fetched by the latest single read.
// - Indexes 0x37 to 0x5f are unimplemented.
// - Indexes 0x61 to 0x8f are unimplemented.
// - Motor hold bit 1 stops motor control, 0 re-enables it.
// - The motor hold bit is write-only and reads as zero.
// - Reserved fields read as zero.
// - The location register selects the single access target; here the single_access_location input does.
`timescale 1ns/1ps
module nv_access_regs (
  input wire logic clk,
  input wire logic reset,
  input nv_access_pkg::reg_req_s bus_req,
  output logic [15:0] bus_rdata,
  output logic bus_hit,
  input wire logic [7:0] single_access_location,
  input wire logic [15:0] shadow_rdata,
  input wire logic [15:0] storage_rdata,
  input wire logic nv_done,
  input wire logic [15:0] nv_rdata,
  output nv_access_pkg::nv_req_s nv_req,
  output logic nv_busy,
  output logic shadow_reload,
  output logic use_shadow,
  output logic bulk_enable,
  output logic motor_hold
);
  logic [15:0] single_write_word_r;
  logic [15:0] ctrl_r;
  logic [15:0] single_read_word;
  logic rd_valid;
  logic go;
  logic [15:0] rdata_nxt;
  logic hit_nxt;

  function automatic logic wr_to(input nv_access_pkg::reg_req_s r,
                                 input logic [7:0] off);
    return r.wr && (r.addr == off);
  endfunction

  function automatic logic unmapped(input logic [7:0] a);
    return ((a >= nv_access_pkg::GAP1_LO) && (a <= nv_access_pkg::GAP1_HI))
      || ((a >= nv_access_pkg::GAP2_LO) && (a <= nv_access_pkg::GAP2_HI));
  endfunction

  wire logic shadow_override_enable = ctrl_r[nv_access_pkg::BIT_SHADOW];
  wire logic storage_direction = ctrl_r[nv_access_pkg::BIT_DIR];
  wire logic [1:0] storage_access_select = ctrl_r[1:0];

  always_ff @(posedge clk) begin
    if (reset) begin
      single_write_word_r <= nv_access_pkg::RESET_WORD;
    end else if (wr_to(bus_req, nv_access_pkg::OFF_WRITE_WORD)) begin
      single_write_word_r <= bus_req.wdata;
    end
  end

  // Reload bit self-clears after one pulse so software sees completion
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_r <= nv_access_pkg::RESET_WORD;
    end else if (wr_to(bus_req, nv_access_pkg::OFF_ACCESS_CTRL)) begin
      ctrl_r <= bus_req.wdata & nv_access_pkg::CTRL_MASK;
    end else begin
      ctrl_r[nv_access_pkg::BIT_RELOAD] <= 1'b0;
    end
  end

  assign shadow_reload = ctrl_r[nv_access_pkg::BIT_RELOAD];
  assign use_shadow = shadow_override_enable;
  assign bulk_enable =
    (storage_access_select == nv_access_pkg::MODE_BULK);

  always_ff @(posedge clk) begin
    if (reset) begin
      motor_hold <= 1'b0;
    end else if (wr_to(bus_req, nv_access_pkg::OFF_MOTOR_HOLD)) begin
      motor_hold <= bus_req.wdata[nv_access_pkg::BIT_MOTOR_HOLD];
    end
  end

  // Write word starts a store, read word write starts a fetch
  // Direction gates the trigger so a stray write never stores stale data
  assign go = (storage_access_select == nv_access_pkg::MODE_SINGLE)
    && !nv_busy && !wr_to(bus_req, nv_access_pkg::OFF_ACCESS_CTRL)
    && (storage_direction ? wr_to(bus_req, nv_access_pkg::OFF_WRITE_WORD)
        : wr_to(bus_req, nv_access_pkg::OFF_READ_WORD));

  nv_single_seq u_seq (
    .clk(clk),
    .reset(reset),
    .go(go),
    .write(storage_direction),
    .loc(single_access_location),
    .wdata(wr_to(bus_req, nv_access_pkg::OFF_WRITE_WORD) ?
           bus_req.wdata : single_write_word_r),
    .nv_done(nv_done),
    .nv_rdata(nv_rdata),
    .nv_req(nv_req),
    .busy(nv_busy),
    .rd_valid(rd_valid),
    .rd_data(single_read_word)
  );

  always_comb begin
    rdata_nxt = 16'h0000;
    hit_nxt = bus_req.rd && !unmapped(bus_req.addr);
    case (bus_req.addr)
      nv_access_pkg::OFF_WRITE_WORD: rdata_nxt = single_write_word_r;
      nv_access_pkg::OFF_ACCESS_CTRL: rdata_nxt = ctrl_r;
      nv_access_pkg::OFF_READ_WORD: rdata_nxt = single_read_word;
      nv_access_pkg::OFF_MOTOR_HOLD: rdata_nxt = 16'h0000;
      default: begin
        if (unmapped(bus_req.addr)) begin
          rdata_nxt = 16'h0000;
        end else if (shadow_override_enable) begin
          rdata_nxt = shadow_rdata;
        end else begin
          rdata_nxt = storage_rdata;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bus_rdata <= 16'h0000;
      bus_hit <= 1'b0;
    end else begin
      bus_rdata <= bus_req.rd ? rdata_nxt : 16'h0000;
      bus_hit <= hit_nxt;
    end
  end

  chk_reload_pulse: assert property (@(posedge clk) disable iff (reset)
    shadow_reload |=> !shadow_reload ||
      $past(wr_to(bus_req, nv_access_pkg::OFF_ACCESS_CTRL)))
    else $error("reload bit held");
  chk_hold_read_zero: assert property (@(posedge clk) disable iff (reset)
    (bus_req.rd && bus_req.addr == nv_access_pkg::OFF_MOTOR_HOLD)
      |=> bus_rdata == 16'h0000)
    else $error("motor hold readable");
  chk_hold_follows: assert property (@(posedge clk) disable iff (reset)
    wr_to(bus_req, nv_access_pkg::OFF_MOTOR_HOLD)
      |=> motor_hold ==
        $past(bus_req.wdata[nv_access_pkg::BIT_MOTOR_HOLD]))
    else $error("motor hold not taken");
  chk_gap_zero: assert property (@(posedge clk) disable iff (reset)
    (bus_req.rd && bus_req.addr >= nv_access_pkg::GAP1_LO
      && bus_req.addr <= nv_access_pkg::GAP1_HI)
      |=> !bus_hit && bus_rdata == 16'h0000)
    else $error("unmapped index answered");
  chk_gap2_zero: assert property (@(posedge clk) disable iff (reset)
    (bus_req.rd && bus_req.addr >= nv_access_pkg::GAP2_LO
      && bus_req.addr <= nv_access_pkg::GAP2_HI)
      |=> !bus_hit && bus_rdata == 16'h0000)
    else $error("upper gap answered");
  chk_ctrl_reserved: assert property (@(posedge clk) disable iff (reset)
    (ctrl_r & ~nv_access_pkg::CTRL_MASK) == 16'h0000)
    else $error("reserved control bit set");
  chk_single_only: assert property (@(posedge clk) disable iff (reset)
    $rose(nv_req.req) |->
      $past(storage_access_select) == nv_access_pkg::MODE_SINGLE)
    else $error("access outside single mode");
  chk_dir_loc: assert property (@(posedge clk) disable iff (reset)
    go |=> nv_req.write == $past(storage_direction)
      && nv_req.loc == $past(single_access_location))
    else $error("wrong direction or location");
  chk_read_word: assert property (@(posedge clk) disable iff (reset)
    (nv_busy && !nv_req.write && nv_done) |=> ##1 single_read_word ==
      $past(nv_rdata, 2))
    else $error("read word not captured");
  chk_read_valid: assert property (@(posedge clk) disable iff (reset)
    (nv_busy && !nv_req.write && nv_done) |=> rd_valid)
    else $error("read completion not flagged");
endmodule // nv_access_regs

// file: nv_store_model.sv
// Purpose: Behavioural storage array answering single accesses
// Assumes: Request stands until the edge after done
// Notes: Read data is scrambled outside the done cycle
`timescale 1ns/1ps
module nv_store_model (
  input wire logic clk,
  input wire logic reset,
  input nv_access_pkg::nv_req_s nv_req,
  input wire logic [3:0] delay,
  output logic nv_done,
  output logic [15:0] nv_rdata
);
  logic [15:0] mem_r [256];
  logic [3:0] cnt_r;
  always_ff @(posedge clk) begin
    nv_done <= 1'b0;
    // Stale data must not look valid
    nv_rdata <= ~nv_rdata;
    if (reset) begin
      cnt_r <= 4'h0;
      nv_rdata <= 16'h0000;
    end else if (nv_req.req && !nv_done) begin
      if (cnt_r == delay) begin
        cnt_r <= 4'h0;
        nv_done <= 1'b1;
        if (nv_req.write) begin
          mem_r[nv_req.loc] <= nv_req.wdata;
        end else begin
          nv_rdata <= mem_r[nv_req.loc];
        end
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end
endmodule // nv_store_model

// file: nv_access_regs_tb_top.sv
// Purpose: Register level tests of the storage access block
// Assumes: Read data and hit valid the cycle after a read
// Notes: Shadow and normal contents are tagged by their top byte
`timescale 1ns/1ps
module nv_access_regs_tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  nv_access_pkg::reg_req_s req = '0;
  logic [7:0] loc = 8'h90;
  logic [3:0] delay = 4'h6;
  logic [15:0] rdata, nv_rdata;
  logic hit, nv_done, busy, reload, use_sh, bulk, hold;
  nv_access_pkg::nv_req_s nv_req;
  int miscompares = 0;
  int compares = 0;
  always #50 clk = ~clk;
  nv_access_regs i_dut (.clk(clk), .reset(reset), .bus_req(req),
    .bus_rdata(rdata), .bus_hit(hit), .single_access_location(loc),
    .shadow_rdata({8'ha5, req.addr}), .storage_rdata({8'h5a, req.addr}),
    .nv_done(nv_done), .nv_rdata(nv_rdata), .nv_req(nv_req),
    .nv_busy(busy), .shadow_reload(reload), .use_shadow(use_sh),
    .bulk_enable(bulk), .motor_hold(hold));
  nv_store_model i_store (.clk(clk), .reset(reset), .nv_req(nv_req),
    .delay(delay), .nv_done(nv_done), .nv_rdata(nv_rdata));
  task automatic chk(input string n, input logic [15:0] g, e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge clk);
    req.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e,
                    input logic h);
    @(posedge clk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    chk("read data", rdata, e);
    chk("hit", {15'h0, hit}, {15'h0, h});
  endtask
  task automatic wait_req(input logic busy_end);
    for (int i = 0; i < 40 && nv_req.req === busy_end; i++) begin
      @(posedge clk);
      #1;
    end
    chk("request", {15'h0, nv_req.req}, {15'h0, !busy_end});
  endtask
  task automatic finish_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rd(8'h34, 16'h0000, 1'b1);
    rd(8'h35, 16'h0000, 1'b1);
    rd(8'h36, 16'h0000, 1'b1);
    rd(8'h60, 16'h0000, 1'b1);
    wr(8'h35, 16'h1106);
    chk("reload", {15'h0, reload}, 16'h0001);
    chk("shadow", {15'h0, use_sh}, 16'h0001);
    chk("bulk", {15'h0, bulk}, 16'h0001);
    rd(8'h35, 16'h1006, 1'b1);
    rd(8'h90, 16'ha590, 1'b1);
    wr(8'h35, 16'h0005);
    chk("bulk off", {15'h0, bulk}, 16'h0000);
    rd(8'h90, 16'h5a90, 1'b1);
    wr(8'h34, 16'hbeef);
    wait_req(1'b0);
    chk("nv write", {nv_req.write, nv_req.loc}, 9'h190);
    chk("nv data", nv_req.wdata, 16'hbeef);
    wait_req(1'b1);
    @(posedge clk);
    delay <= 4'h0;
    wr(8'h35, 16'h0001);
    wr(8'h36, 16'h0000);
    wait_req(1'b0);
    chk("nv read", {nv_req.write, nv_req.loc}, 9'h090);
    wait_req(1'b1);
    rd(8'h36, 16'hbeef, 1'b1);
    @(posedge clk);
    loc <= 8'h91;
    wr(8'h35, 16'h0005);
    wr(8'h34, 16'hcafe);
    wait_req(1'b0);
    chk("nv write 2", {busy, nv_req.write, nv_req.loc}, 10'h391);
    wait_req(1'b1);
    wr(8'h35, 16'h0001);
    wr(8'h36, 16'h0000);
    wait_req(1'b0);
    chk("nv read 2", {nv_req.write, nv_req.loc}, 9'h091);
    wait_req(1'b1);
    rd(8'h36, 16'hcafe, 1'b1);
    wr(8'h35, 16'h0000);
    wr(8'h34, 16'h1234);
    repeat (4) @(posedge clk);
    #1;
    chk("no access", {15'h0, nv_req.req}, 16'h0000);
    rd(8'h34, 16'h1234, 1'b1);
    rd(8'h37, 16'h0000, 1'b0);
    rd(8'h5f, 16'h0000, 1'b0);
    rd(8'h61, 16'h0000, 1'b0);
    rd(8'h8f, 16'h0000, 1'b0);
    wr(8'h60, 16'h8000);
    chk("hold on", {15'h0, hold}, 16'h0001);
    rd(8'h60, 16'h0000, 1'b1);
    wr(8'h60, 16'h0000);
    chk("hold off", {15'h0, hold}, 16'h0000);
    finish_test();
  end
endmodule // nv_access_regs_tb_top
